// file: verilog/fault_loop_pkg.sv
// Constants and types for the fault log loop readout.
// Assumes a single 100 MHz system clock domain.
package fault_loop_pkg;

  localparam int unsigned LOOP_BYTES   = 54;
  localparam int unsigned NUM_LOOPS    = 4;
  localparam int unsigned POS_W        = 6;
  localparam int unsigned REC_W        = 2;
  localparam int unsigned BNUM_W       = 8;
  localparam logic [7:0]  FIRST_BYTE   = 8'h47;  // Block-read byte 71
  localparam logic [7:0]  LAST_BYTE    = 8'hed;  // Block-read byte 237
  localparam logic [5:0]  POS_TOP      = 6'h35;  // Highest position, 53
  localparam logic [5:0]  POS_ZERO     = 6'h00;
  localparam logic [5:0]  PAGE0_BASE   = 6'h02;
  localparam logic [5:0]  INPUT_BASE   = 6'h0e;
  localparam logic [5:0]  PAGE1_BASE   = 6'h12;
  localparam logic [5:0]  GROUP_BYTES  = 6'h0c;
  localparam logic [5:0]  VIN_LO_POS   = 6'h0e;
  localparam logic [5:0]  VIN_HI_POS   = 6'h0f;
  localparam logic [5:0]  INSTAT_POS   = 6'h10;
  localparam logic [7:0]  PAD_BYTE     = 8'h00;
  localparam logic [1:0]  PAGE_ZERO    = 2'h0;

  typedef enum logic [4:0] {
    F_TEMP2_LO   = 5'h00,
    F_TEMP2_HI   = 5'h01,
    F_VOUT_LO    = 5'h02,
    F_VOUT_HI    = 5'h03,
    F_VOUT_STAT  = 5'h04,
    F_MFR_STAT   = 5'h05,
    F_TEMP1_LO   = 5'h06,
    F_TEMP1_HI   = 5'h07,
    F_TEMP_STAT  = 5'h08,
    F_IOUT_STAT  = 5'h09,
    F_IOUT_LO    = 5'h0a,
    F_IOUT_HI    = 5'h0b,
    F_POUT_LO    = 5'h0c,
    F_POUT_HI    = 5'h0d,
    F_VIN_LO     = 5'h0e,
    F_VIN_HI     = 5'h0f,
    F_IN_STAT    = 5'h10,
    F_PAD        = 5'h11
  } field_kind_t;

  typedef struct packed {
    logic [1:0]  page;
    field_kind_t kind;
  } field_tag_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [7:0] byte_num;
    field_tag_t tag;
    logic       last;
  } loop_byte_t;

endpackage

// file: verilog/fault_log_loop_readout.sv
// Cyclical loop section of the fault log block read.
// Assumes the capture side fills the loop store and the bus engine
// issues one byte request per data byte after a start pulse.
//
// What this block does
// - Loop data occupies block-read bytes 71 through 237, ordered by the pointer.
// - Byte 71 carries the entry at the stored last-position pointer, or at position 53 for a pointer above 53.
// - Each later byte carries the position one lower; reader decodes likewise.
// - A record is 54 bytes: temp2, page 0, input group, pages 1 to 3.
// - After position 0 wrap to 53 of the older record until byte 237.
// - Pointer 8 yields page 0 temp status, then temp high, then temp low.
`timescale 1ns/1ns
module fault_log_loop_readout
  import fault_loop_pkg::*;
#(
  parameter int unsigned LOOPS = NUM_LOOPS
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Loop store fill port
  input  wire logic              wr_en,
  input  wire logic [REC_W-1:0]  wr_rec,
  input  wire logic [POS_W-1:0]  wr_pos,
  input  wire logic [7:0]        wr_data,
  // Read control
  input  wire logic              rd_start,
  input  wire logic [POS_W-1:0]  pos_last,
  input  wire logic [REC_W-1:0]  rec_last,
  input  wire logic              rd_req,
  // Read data
  output loop_byte_t             rd_out,
  output logic                   busy
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam logic [1:0]       PAGE_ONE    = 2'h1;
  localparam logic [1:0]       PAGE_TWO    = 2'h2;
  localparam logic [1:0]       PAGE_THREE  = 2'h3;
  localparam logic [3:0]       KIND_UPPER  = 4'h0;
  localparam logic [5:0]       GROUP_TWICE = GROUP_BYTES + GROUP_BYTES;
  localparam logic [7:0]       BYTE_STEP   = 8'h01;
  localparam int unsigned      STORE_DEPTH = LOOPS * LOOP_BYTES;
  localparam logic [REC_W-1:0] REC_OLDEST  = REC_W'(LOOPS - 32'h1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // One bit is enough: idle or reading
  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_RUN  = 1'b1
  } rd_phase_t;

  // Whole readout state, registered in one place
  typedef struct packed {
    rd_phase_t        phase;
    logic [POS_W-1:0] pos;
    logic [REC_W-1:0] rec;
    logic [7:0]       bnum;
    logic             busy;
    loop_byte_t       out;
  } state_t;

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  // Field held at one loop position
  function automatic field_tag_t field_of(input logic [POS_W-1:0] pos);
    field_tag_t t;
    logic [5:0] off;
    t   = '{page: PAGE_ZERO, kind: F_PAD};
    off = POS_ZERO;
    if (pos < PAGE0_BASE) begin
      t.kind = field_kind_t'({KIND_UPPER, pos[0]});
    end else if (pos < INPUT_BASE) begin
      off    = pos - PAGE0_BASE;
      t.kind = field_kind_t'(5'(off + PAGE0_BASE));
    end else if (pos < PAGE1_BASE) begin
      case (pos)
        VIN_LO_POS: t.kind = F_VIN_LO;
        VIN_HI_POS: t.kind = F_VIN_HI;
        INSTAT_POS: t.kind = F_IN_STAT;
        default:    t.kind = F_PAD;
      endcase
    end else begin
      off = pos - PAGE1_BASE;
      if (off < GROUP_BYTES) begin
        t.page = PAGE_ONE;
      end else if (off < GROUP_TWICE) begin
        t.page = PAGE_TWO;
        off    = off - GROUP_BYTES;
      end else begin
        t.page = PAGE_THREE;
        off    = off - GROUP_TWICE;
      end
      t.kind = field_kind_t'(5'(off + PAGE0_BASE));
    end
    return t;
  endfunction

  // Flat index of one byte in the loop store
  function automatic int unsigned store_addr(input logic [REC_W-1:0] rec,
                                             input logic [POS_W-1:0] pos);
    return 32'(rec) * LOOP_BYTES + 32'(pos);
  endfunction

  // Record written before the given one, wrapping at the oldest slot
  function automatic logic [REC_W-1:0] older_rec(input logic [REC_W-1:0] rec);
    return (rec == '0) ? REC_OLDEST : rec - 1'b1;
  endfunction

  // Pointers past the top of a record start at the top instead
  function automatic logic [POS_W-1:0] first_pos(input logic [POS_W-1:0] pl);
    return (pl > POS_TOP) ? POS_TOP : pl;
  endfunction

  // ----------------------------------------------------------------
  // Position tag table
  // ----------------------------------------------------------------
  // One constant decode per position keeps the read path a plain lookup
  field_tag_t pos_tag [LOOP_BYTES];
  logic       pos_pad [LOOP_BYTES];

  for (genvar g = 0; g < LOOP_BYTES; g++) begin : g_tag
    assign pos_tag[g] = field_of(POS_W'(g));
    assign pos_pad[g] = (pos_tag[g].kind == F_PAD);
  end

  // ----------------------------------------------------------------
  // Loop store
  // ----------------------------------------------------------------
  // Not reset: contents are defined only once the capture side writes them
  // Limitation: a record index at or above LOOPS is not screened
  logic [7:0] store [STORE_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en && (wr_pos <= POS_TOP)) begin
      store[store_addr(wr_rec, wr_pos)] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Readout state
  // ----------------------------------------------------------------
  state_t     st_ff;
  state_t     nxt_st;
  logic [7:0] rd_byte;
  logic       rd_take;
  logic       at_wrap;
  logic       at_end;

  // Padding position reads as zero whatever the store holds
  assign rd_byte = pos_pad[st_ff.pos] ? PAD_BYTE :
                   store[store_addr(st_ff.rec, st_ff.pos)];

  // A start in the same cycle wins over a byte request
  assign rd_take = (st_ff.phase == RD_RUN) && rd_req && !rd_start;
  assign at_wrap = (st_ff.pos == POS_ZERO);
  assign at_end  = (st_ff.bnum == LAST_BYTE);

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.out.valid = 1'b0;
    nxt_st.out.last  = 1'b0;
    case (st_ff.phase)
      RD_IDLE: begin
        // Stray byte requests are dropped until a read starts
        nxt_st.phase = RD_IDLE;
      end
      RD_RUN: begin
        if (rd_take) begin
          nxt_st.out.valid    = 1'b1;
          nxt_st.out.data     = rd_byte;
          nxt_st.out.byte_num = st_ff.bnum;
          nxt_st.out.tag      = pos_tag[st_ff.pos];
          nxt_st.out.last     = at_end;
          nxt_st.bnum         = st_ff.bnum + BYTE_STEP;
          // Position 0 is followed by the top of the older record
          if (at_wrap) begin
            nxt_st.pos = POS_TOP;
            nxt_st.rec = older_rec(st_ff.rec);
          end else begin
            nxt_st.pos = st_ff.pos - 1'b1;
          end
          if (at_end) begin
            nxt_st.phase = RD_IDLE;
          end
        end
      end
      default: begin
        nxt_st.phase = RD_IDLE;
      end
    endcase
    if (rd_start) begin
      // A restart abandons any read in progress
      nxt_st.phase = RD_RUN;
      nxt_st.pos   = first_pos(pos_last);
      nxt_st.rec   = rec_last;
      nxt_st.bnum  = FIRST_BYTE;
    end
    nxt_st.busy = (nxt_st.phase == RD_RUN);
  end

  // Asynchronous clear: output byte and busy read zero in reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_out = st_ff.out;
  assign busy   = st_ff.busy;

endmodule // fault_log_loop_readout

// file: tb/loop_host.sv
// Bus host model: requests loop bytes while a read runs.
// Assumes the bench seeds the random source.
`timescale 1ns/1ns
module loop_host (
  // Bus side
  input  wire logic clk,
  input  wire logic busy,
  output logic      rd_req
);
  initial rd_req = 1'b0;
  // Random gaps act as a slow host; stray requests while idle must be ignored
  always @(negedge clk) rd_req <= busy ? ($urandom % 3 != 0) : ($urandom % 4 == 0);
endmodule // loop_host

// file: tb/fault_loop_checker.sv
// Port checks of the loop readout.
// Assumes one clock; bound to the top module.
`timescale 1ns/1ns
module fault_loop_checker
  import fault_loop_pkg::*;
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       rd_start,
  input wire logic       rd_req,
  input wire loop_byte_t rd_out,
  input wire logic       busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_ans; rd_req && busy && !rd_start |=> rd_out.valid; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_idle; !busy |=> !rd_out.valid; endproperty
  a_idle: assert property (p_idle) else $error("byte when idle");
  property p_start; rd_start |=> busy && !rd_out.valid; endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_range; rd_out.valid |-> rd_out.byte_num inside {[71:237]}; endproperty
  a_range: assert property (p_range) else $error("byte out of range");
  property p_step; rd_out.valid && !rd_start ##1 rd_out.valid
    |-> rd_out.byte_num == $past(rd_out.byte_num) + 8'h01; endproperty
  a_step: assert property (p_step) else $error("byte skipped");
  property p_last; rd_out.last |-> rd_out.valid && rd_out.byte_num == LAST_BYTE && !busy;
  endproperty
  a_last: assert property (p_last) else $error("bad last");
  property p_pad; rd_out.valid && rd_out.tag.kind == F_PAD |-> rd_out.data == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("pad not zero");
  property p_temp; rd_out.valid && rd_out.tag.kind == F_TEMP_STAT && !rd_start ##1
    rd_out.valid |-> rd_out.tag.kind == F_TEMP1_HI && $stable(rd_out.tag.page); endproperty
  a_temp: assert property (p_temp) else $error("bad temp order");
endmodule // fault_loop_checker
bind fault_log_loop_readout fault_loop_checker i_fault_loop_checker (.clk(clk),
  .sys_rst(sys_rst), .rd_start(rd_start), .rd_req(rd_req), .rd_out(rd_out), .busy(busy));

// file: tb/tb.sv
// Bench: fills the loop store, reads it at several pointers.
// Assumes the host model paces the byte requests.
`timescale 1ns/1ns
module tb;
  import fault_loop_pkg::*;
  logic clk = 0, sys_rst = 1, wr_en = 0, rd_start = 0, rd_req, busy;
  logic [1:0] wr_rec = 0, rec_last = 0;
  logic [5:0] wr_pos = 0, pos_last = 0;
  logic [7:0] wr_data = 0;
  loop_byte_t rd_out;
  logic [7:0] mem [4][54];
  int failures = 0, cmp_count = 0, k, q, rc, p0, r0, w;
  always #5 clk = ~clk;
  fault_log_loop_readout i_fault_log_loop_readout (.clk(clk), .sys_rst(sys_rst),
    .wr_en(wr_en), .wr_rec(wr_rec), .wr_pos(wr_pos), .wr_data(wr_data), .rd_start(rd_start),
    .pos_last(pos_last), .rec_last(rec_last), .rd_req(rd_req), .rd_out(rd_out), .busy(busy));
  loop_host i_loop_host (.clk(clk), .busy(busy), .rd_req(rd_req));
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [6:0] exp_tag(int p);
    return {p < 18 ? 2'h0 : 2'((p - 6) / 12), 5'(p < 18 ? p : 2 + (p - 18) % 12)};
  endfunction
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic read_once(input logic [5:0] pl, input int i);
    k = 0;
    {pos_last, rec_last, rd_start} = {pl, 2'(r0), 1'b1};
    @(negedge clk);
    rd_start = 0;
    for (w = 0; busy !== 1'b0 && w < 1000; w++) @(negedge clk);
    if (w == 1000) begin
      failures++;
      end_sim;
    end
    // The last byte is decoded at this same edge; let it land first
    @(negedge clk);
    chk("count", 167, k);
    $display("test %0d done", i);
  endtask
  // ------------------------------
  // Descending decode of each byte
  // ------------------------------
  always @(negedge clk) if (rd_out.valid === 1'b1) begin
    q = (p0 + 216 - k) % 54;
    rc = (r0 + 4 - (k + 53 - p0) / 54) % 4;
    chk("data", q == 17 ? 8'h00 : mem[rc][q], rd_out.data);
    chk("byte_num", 71 + k, rd_out.byte_num);
    chk("tag", exp_tag(q), rd_out.tag);
    chk("last", k == 166, rd_out.last);
    k++;
  end
  initial begin
    k = $urandom(32'hfe9c767c);
    repeat (16) @(negedge clk);
    sys_rst = 0;
    for (int r = 0; r < 4; r++) for (int p = 0; p < 54; p++) begin
      mem[r][p] = 8'($urandom);
      {wr_en, wr_rec, wr_pos, wr_data} = {1'b1, 2'(r), 6'(p), mem[r][p]};
      @(negedge clk);
    end
    wr_en = 0;
    // Corner pointers first, then random ones; test 7 points past the top
    for (int i = 0; i < 8; i++) begin
      p0 = i == 0 ? 8 : i == 1 ? 0 : i == 2 || i == 7 ? 53 : i == 3 ? 13 : $urandom % 54;
      r0 = $urandom % 4;
      read_once(i == 7 ? 6'h3f : 6'(p0), i);
    end
    // Reset in mid-read drops it; then a read at the first edge after release
    p0 = 5;
    r0 = 1;
    k = 0;
    {pos_last, rec_last, rd_start} = {6'h05, 2'h1, 1'b1};
    @(negedge clk);
    rd_start = 0;
    repeat (20) @(negedge clk);
    sys_rst = 1;
    @(negedge clk);
    chk("busy", 1'b0, busy);
    chk("valid", 1'b0, rd_out.valid);
    chk("byte_num", 8'h00, rd_out.byte_num);
    sys_rst = 0;
    read_once(6'(p0), 8);
    end_sim;
  end
endmodule // tb
